//--- logic/eeprom_device.sv
// EEPROM serial read path: address counter, current/random/sequential read, write hand-off.
// Assumes an oversampling clock several times faster than SCL; memory array is outside.
`timescale 1ns/1ps

module eeprom_device
  import eeprom_pkg::*;
(
  input wire logic OVS_CLK,
  input wire logic RST,
  input wire logic SLAVE_SELECT_BIT0,
  input wire logic SLAVE_SELECT_BIT1,
  input wire logic SLAVE_SELECT_BIT2,
  input wire logic LOW_SUPPLY,
  input wire logic WRITE_BUSY,
  input wire logic [7:0] MEM_RDATA,
  output logic [15:0] MEM_ADDR,
  output logic WR_STROBE,
  output logic [15:0] WR_ADDR,
  output logic [7:0] WR_DATA,
  output logic WR_COMMIT,
  output logic WR_CANCEL,
  eeprom_link_if.device LINK
);

  // ==========================================================
  // Declarations
  dev_state_t state_reg;
  logic [3:0] bit_reg;
  logic [7:0] rx_reg;
  logic [7:0] tx_reg;
  logic oe_reg;
  logic acked_reg;
  logic mack_reg;
  logic [7:0] hi_reg;
  logic [15:0] cnt_reg;
  logic wr_pend_reg;
  logic wr_strobe_reg;
  logic [15:0] wr_addr_reg;
  logic [7:0] wr_data_reg;
  logic commit_reg;
  logic cancel_reg;
  logic [6:0] pin_s1;
  logic [6:0] pin_s2;
  logic [6:0] pin_d;
  logic scl_q;
  logic scl_d;
  logic sda_q;
  logic sda_d;
  logic low_sup;
  logic busy;
  logic [2:0] sel;
  logic start_det;
  logic stop_det;
  logic scl_rise;
  logic scl_fall;
  logic ack_c;

  // ==========================================================
  // Pin synchronisers
  // Two flops on every pin; pin_d keeps the previous settled sample for edges
  always_ff @(posedge OVS_CLK or posedge RST) begin
    if (RST) begin
      pin_s1 <= PIN_RESET;
      pin_s2 <= PIN_RESET;
      pin_d <= PIN_RESET;
    end else begin
      pin_s1 <= {LINK.scl, LINK.sda, LOW_SUPPLY, WRITE_BUSY, SLAVE_SELECT_BIT2, SLAVE_SELECT_BIT1,
                 SLAVE_SELECT_BIT0};
      pin_s2 <= pin_s1;
      pin_d <= pin_s2;
    end
  end

  // Settled pin levels
  assign scl_q = pin_s2[6];
  assign scl_d = pin_d[6];
  assign sda_q = pin_s2[5];
  assign sda_d = pin_d[5];
  assign low_sup = pin_s2[4];
  assign busy = pin_s2[3];
  assign sel = pin_s2[2:0];

  // ==========================================================
  // Bus conditions
  // SDA moving while SCL stays high marks start and stop
  assign start_det = scl_q & scl_d & sda_d & ~sda_q;
  assign stop_det = scl_q & scl_d & ~sda_d & sda_q;
  assign scl_rise = scl_q & ~scl_d;
  assign scl_fall = ~scl_q & scl_d;

  // Acknowledge decision for a received byte
  always_comb begin
    ack_c = 1'b1;
    if (state_reg == D_DEVADDR) begin
      ack_c = (rx_reg[7:1] == {DEV_CODE, sel}) && !busy;
    end
  end

  // ==========================================================
  // Serial state machine
  // Only start and stop force the machine; there is no user reset
  always_ff @(posedge OVS_CLK or posedge RST) begin
    if (RST) begin
      state_reg <= D_IDLE;
      bit_reg <= 4'h0;
      rx_reg <= 8'h00;
      tx_reg <= 8'hFF;
      oe_reg <= 1'b0;
      acked_reg <= 1'b0;
      mack_reg <= 1'b0;
    end else if (start_det) begin
      state_reg <= D_DEVADDR;
      bit_reg <= 4'h0;
      oe_reg <= 1'b0;
    end else if (stop_det) begin
      state_reg <= D_IDLE;
      bit_reg <= 4'h0;
      oe_reg <= 1'b0;
    end else if (state_reg != D_IDLE) begin
      if (scl_rise) begin
        bit_reg <= 4'(bit_reg + 4'h1);
        if (bit_reg < ACK_SLOT) begin
          rx_reg <= {rx_reg[6:0], sda_q};
        end
        if (state_reg == D_READ && bit_reg == ACK_SLOT) begin
          mack_reg <= ~sda_q; // Master ack or nack on ninth clock
        end
      end else if (scl_fall) begin
        if (bit_reg == ACK_SLOT) begin
          if (state_reg == D_READ) begin
            oe_reg <= 1'b0; // Release for the master's acknowledge
          end else begin
            acked_reg <= ack_c;
            oe_reg <= ack_c;
          end
        end else if (bit_reg == BYTE_END) begin
          bit_reg <= 4'h0;
          oe_reg <= 1'b0;
          unique case (state_reg)
            D_DEVADDR: begin
              if (!acked_reg) begin
                state_reg <= D_IDLE;
              end else if (rx_reg[0]) begin
                state_reg <= D_READ;
                tx_reg <= MEM_RDATA;
                oe_reg <= ~MEM_RDATA[7];
              end else begin
                state_reg <= D_ADDRH;
              end
            end
            D_ADDRH: begin
              state_reg <= D_ADDRL;
            end
            D_ADDRL: begin
              state_reg <= D_WDATA;
            end
            D_WDATA: begin
              state_reg <= D_WDATA;
            end
            D_READ: begin
              if (mack_reg) begin
                tx_reg <= MEM_RDATA;
                oe_reg <= ~MEM_RDATA[7];
              end else begin
                state_reg <= D_IDLE;
              end
            end
            default: begin
              state_reg <= D_IDLE;
            end
          endcase
        end else if (state_reg == D_READ && bit_reg != 4'h0) begin
          tx_reg <= {tx_reg[6:0], 1'b1};
          oe_reg <= ~tx_reg[6];
        end
      end
    end
  end

  // ==========================================================
  // Address counter and write hand-off
  // Counter survives start and stop; only power-on clears it
  always_ff @(posedge OVS_CLK or posedge RST) begin
    if (RST) begin
      cnt_reg <= ADDR_RESET;
      hi_reg <= 8'h00;
      wr_pend_reg <= 1'b0;
      wr_strobe_reg <= 1'b0;
      wr_addr_reg <= ADDR_RESET;
      wr_data_reg <= 8'h00;
      commit_reg <= 1'b0;
      cancel_reg <= 1'b0;
    end else begin
      wr_strobe_reg <= 1'b0;
      commit_reg <= 1'b0;
      cancel_reg <= 1'b0;
      if (start_det) begin
        wr_pend_reg <= 1'b0; // Start cancels a command being input
      end else if (stop_det) begin
        if (state_reg == D_WDATA && wr_pend_reg && bit_reg == 4'h0) begin
          commit_reg <= ~low_sup;
          cancel_reg <= low_sup;
        end
        wr_pend_reg <= 1'b0;
      end else if (scl_fall && bit_reg == ACK_SLOT) begin
        unique case (state_reg)
          D_ADDRH: begin
            hi_reg <= rx_reg;
          end
          D_ADDRL: begin
            cnt_reg <= {hi_reg, rx_reg};
          end
          D_WDATA: begin
            wr_strobe_reg <= 1'b1;
            wr_addr_reg <= cnt_reg;
            wr_data_reg <= rx_reg;
            wr_pend_reg <= 1'b1;
            cnt_reg[PAGE_LOW_W-1:0] <= cnt_reg[PAGE_LOW_W-1:0] + 7'h01;
          end
          D_READ: begin
            cnt_reg <= 16'(cnt_reg + 16'h0001);
          end
          D_IDLE, D_DEVADDR: begin
            cnt_reg <= cnt_reg;
          end
          default: begin
            cnt_reg <= cnt_reg;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Outputs
  assign MEM_ADDR = cnt_reg;
  assign WR_STROBE = wr_strobe_reg;
  assign WR_ADDR = wr_addr_reg;
  assign WR_DATA = wr_data_reg;
  assign WR_COMMIT = commit_reg;
  assign WR_CANCEL = cancel_reg;
  assign LINK.sda_s_o = 1'b0; // Open drain: only ever pulls low
  assign LINK.sda_s_oe = oe_reg;

endmodule : eeprom_device

//--- logic/eeprom_pkg.sv
// Shared constants and types of the two-wire EEPROM read path and its bus master.
// Assumes one master and one slave on a pulled-up open-drain SDA line.

package eeprom_pkg;

  // ==========================================================
  // Framing
  localparam logic [3:0] DEV_CODE = 4'hA;
  localparam int PAGE_LOW_W = 7;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] BYTE_END = 4'h9;
  localparam logic [8:0] IDLE_WORD = 9'h1FF;
  localparam logic [15:0] ADDR_RESET = 16'h0000;
  localparam logic [6:0] PIN_RESET = 7'h60;

  // ==========================================================
  // Master timing
  localparam int REF_PERIOD_NS = 100;
  localparam int SCL_QUARTER_NS = 1000;
  localparam int QTR_CYC_INT = (SCL_QUARTER_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
  localparam logic [7:0] QTR_LAST = 8'(QTR_CYC_INT - 1);

  // ==========================================================
  // Enumerations
  typedef enum logic [1:0] {OP_CURRENT, OP_RANDOM, OP_RECOVER} cmd_op_t;
  typedef enum logic [3:0] {M_IDLE, M_START1, M_DEVW, M_ADDRH, M_ADDRL, M_START2, M_DEVR, M_READ,
                            M_DUMMY, M_START3, M_STOP} mst_state_t;
  typedef enum logic [2:0] {D_IDLE, D_DEVADDR, D_ADDRH, D_ADDRL, D_WDATA, D_READ} dev_state_t;

endpackage : eeprom_pkg

//--- logic/eeprom_link_if.sv
// Two-wire link between the bus master and the EEPROM read path.
// Assumes both ends drive SDA open-drain; the wire level is resolved here.
`timescale 1ns/1ps

interface eeprom_link_if;
  logic scl;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic sda;

  // ==========================================================
  // Wired-AND with pull-up
  assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));

  modport master (output scl, output sda_m_o, output sda_m_oe, input sda);
  modport device (input scl, input sda, output sda_s_o, output sda_s_oe);
endinterface : eeprom_link_if

//--- logic/eeprom_master.sv
// Two-wire bus master for the EEPROM read path: current, random read and bus recovery.
// Assumes REF_CLK at 10 MHz; SCL is made by dividing it and driven out.
`timescale 1ns/1ps

module eeprom_master
  import eeprom_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic CMD_VALID,
  output logic CMD_READY,
  input wire cmd_op_t CMD_OP,
  input wire logic [15:0] CMD_ADDR,
  input wire logic [7:0] CMD_LEN,
  input wire logic [2:0] CMD_SEL,
  output logic RD_VALID,
  output logic [7:0] RD_DATA,
  output logic DONE,
  output logic NACK,
  eeprom_link_if.master LINK
);

  // ==========================================================
  // Declarations
  mst_state_t state_reg;
  cmd_op_t op_reg;
  logic [15:0] addr_reg;
  logic [7:0] len_reg;
  logic [2:0] sel_reg;
  logic [7:0] div_reg;
  logic [1:0] q_reg;
  logic [3:0] bit_reg;
  logic [8:0] rx_reg;
  logic scl_reg;
  logic oe_reg;
  logic sda_s1;
  logic sda_s2;
  logic rd_valid_reg;
  logic [7:0] rd_data_reg;
  logic done_reg;
  logic nack_reg;
  logic tick;
  logic step_end;
  logic is_start;
  logic is_bits;
  logic [8:0] tx_word;
  logic [8:0] tx_sh;
  logic scl_c;
  logic oe_c;

  // ==========================================================
  // Quarter-bit timing
  assign tick = (div_reg == QTR_LAST);
  assign step_end = tick && (q_reg == 2'h3) && (state_reg != M_IDLE);
  assign is_start = (state_reg == M_START1) || (state_reg == M_START2) || (state_reg == M_START3);
  assign is_bits = !is_start && (state_reg != M_STOP) && (state_reg != M_IDLE);

  // Divider and quarter counter
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      div_reg <= 8'h00;
      q_reg <= 2'h0;
    end else if (state_reg == M_IDLE || tick) begin
      div_reg <= 8'h00;
      q_reg <= (state_reg == M_IDLE) ? 2'h0 : 2'(q_reg + 2'h1);
    end else begin
      div_reg <= 8'(div_reg + 8'h01);
    end
  end

  // Nine-bit word per byte slot; low bit is the ninth clock
  always_comb begin
    unique case (state_reg)
      M_DEVW: tx_word = {DEV_CODE, sel_reg, 1'b0, 1'b1};
      M_DEVR: tx_word = {DEV_CODE, sel_reg, 1'b1, 1'b1};
      M_ADDRH: tx_word = {addr_reg[15:8], 1'b1};
      M_ADDRL: tx_word = {addr_reg[7:0], 1'b1};
      M_READ: tx_word = {8'hFF, len_reg == 8'h00};
      default: tx_word = IDLE_WORD; // dummy clocks with SDA released
    endcase
    tx_sh = tx_word << bit_reg;
  end

  // Pin pattern per quarter
  always_comb begin
    scl_c = 1'b1;
    oe_c = 1'b0;
    if (is_start) begin
      scl_c = (q_reg == 2'h1) || (q_reg == 2'h2);
      oe_c = q_reg[1];
    end else if (state_reg == M_STOP) begin
      scl_c = (q_reg != 2'h0);
      oe_c = ~q_reg[1];
    end else if (is_bits) begin
      scl_c = (q_reg == 2'h1) || (q_reg == 2'h2);
      oe_c = ~tx_sh[8];
    end
  end

  // SDA synchroniser, pin registers and bit sampling
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      scl_reg <= 1'b1;
      oe_reg <= 1'b0;
      rx_reg <= IDLE_WORD;
    end else begin
      sda_s1 <= LINK.sda;
      sda_s2 <= sda_s1;
      scl_reg <= scl_c;
      oe_reg <= oe_c;
      if (tick && q_reg == 2'h2) begin
        rx_reg <= {rx_reg[7:0], sda_s2};
      end
    end
  end

  // ==========================================================
  // Sequencer
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      state_reg <= M_IDLE;
      op_reg <= OP_CURRENT;
      addr_reg <= ADDR_RESET;
      len_reg <= 8'h00;
      sel_reg <= 3'h0;
      bit_reg <= 4'h0;
      rd_valid_reg <= 1'b0;
      rd_data_reg <= 8'h00;
      done_reg <= 1'b0;
      nack_reg <= 1'b0;
    end else begin
      rd_valid_reg <= 1'b0;
      done_reg <= 1'b0;
      if (state_reg == M_IDLE && CMD_VALID) begin
        state_reg <= M_START1;
        op_reg <= CMD_OP;
        addr_reg <= CMD_ADDR;
        len_reg <= CMD_LEN;
        sel_reg <= CMD_SEL;
        bit_reg <= 4'h0;
        nack_reg <= 1'b0;
      end else if (step_end && is_bits && bit_reg != ACK_SLOT) begin
        bit_reg <= 4'(bit_reg + 4'h1);
      end else if (step_end) begin
        bit_reg <= 4'h0;
        unique case (state_reg)
          M_START1: state_reg <= (op_reg == OP_RECOVER) ? M_DUMMY : (op_reg == OP_RANDOM) ? M_DEVW : M_DEVR;
          M_DEVW, M_ADDRH, M_ADDRL, M_DEVR: begin
            if (rx_reg[0]) begin
              state_reg <= M_STOP;
              nack_reg <= 1'b1;
            end else begin
              state_reg <= (state_reg == M_DEVW) ? M_ADDRH : (state_reg == M_ADDRH) ? M_ADDRL :
                           (state_reg == M_ADDRL) ? M_START2 : M_READ;
            end
          end
          M_START2: state_reg <= M_DEVR;
          M_READ: begin
            rd_valid_reg <= 1'b1;
            rd_data_reg <= rx_reg[8:1];
            if (len_reg == 8'h00) begin
              state_reg <= M_STOP;
            end else begin
              len_reg <= 8'(len_reg - 8'h01);
            end
          end
          M_DUMMY: state_reg <= M_START3;
          M_START3: state_reg <= M_STOP;
          M_STOP: begin
            state_reg <= M_IDLE;
            done_reg <= 1'b1;
          end
          default: state_reg <= M_IDLE;
        endcase
      end
    end
  end

  // ==========================================================
  // Outputs
  assign CMD_READY = (state_reg == M_IDLE);
  assign RD_VALID = rd_valid_reg;
  assign RD_DATA = rd_data_reg;
  assign DONE = done_reg;
  assign NACK = nack_reg;
  assign LINK.scl = scl_reg;
  assign LINK.sda_m_o = 1'b0;
  assign LINK.sda_m_oe = oe_reg;

endmodule : eeprom_master

//--- dv/eeprom_link_chk.sv
// Checker on the two-wire link between the bus master and the EEPROM read path.
// Assumes it is instantiated beside the link interface and sampled on the master clock.
`timescale 1ns/1ps

module eeprom_link_chk
  import eeprom_pkg::*;
(
  input logic ref_clk,
  input logic rst,
  input logic scl,
  input logic sda_m_o,
  input logic sda_m_oe,
  input logic sda_s_o,
  input logic sda_s_oe,
  input logic sda
);
  logic scl_q;
  logic sda_q;
  logic first_byte;
  logic m_ack_last;
  logic [3:0] bit_cnt;
  logic start_ev;
  logic stop_ev;
  logic scl_rise;

  // ==========================================================
  // Bus condition decode
  assign start_ev = scl & scl_q & sda_q & ~sda;
  assign stop_ev = scl & scl_q & ~sda_q & sda;
  assign scl_rise = scl & ~scl_q;

  // Previous pin levels, idle high
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end

  // Clock position inside the nine-clock byte; the high clock of a start counts as one
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bit_cnt <= 4'h0;
    end else if (start_ev | stop_ev) begin
      bit_cnt <= 4'h0;
    end else if (scl_rise) begin
      bit_cnt <= (bit_cnt == ACK_SLOT) ? 4'h0 : 4'(bit_cnt + 4'h1);
    end
  end

  // First byte after a start is the device address
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      first_byte <= 1'b0;
    end else if (start_ev) begin
      first_byte <= 1'b1;
    end else if (stop_ev || (scl_rise && bit_cnt == ACK_SLOT)) begin
      first_byte <= 1'b0;
    end
  end

  // Master drive level at the latest ninth clock
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      m_ack_last <= 1'b0;
    end else if (scl_rise && bit_cnt == ACK_SLOT) begin
      m_ack_last <= sda_m_oe;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  chk_open_drain_low: assert property (sda_m_o == 1'b0 && sda_s_o == 1'b0)
    else $error("SDA driver value is not low");
  chk_dev_change_low: assert property ($changed(sda_s_oe) |-> !scl)
    else $error("Device changed SDA while SCL high");
  chk_addr_listen: assert property ((scl_rise && first_byte && bit_cnt < ACK_SLOT) |-> !sda_s_oe)
    else $error("Device drove SDA during the address bits");
  chk_master_ack_free: assert property ((scl_rise && first_byte && bit_cnt == ACK_SLOT) |-> !sda_m_oe)
    else $error("Master drove the address acknowledge slot");
  chk_stop_idle: assert property (stop_ev |-> !sda_s_oe [*8])
    else $error("Device drove SDA after a stop");
  chk_start_idle: assert property (start_ev |-> !sda_s_oe [*8])
    else $error("Device drove SDA after a start");
  chk_stop_after_nack: assert property (stop_ev |-> !m_ack_last)
    else $error("Stop not preceded by an undriven ninth clock");
  chk_start_aligned: assert property (start_ev |-> bit_cnt == 4'h1)
    else $error("Start placed inside a nine-clock group");
endmodule : eeprom_link_chk

//--- dv/serial_eeprom_read_path_bench.sv
// Testbench joining the bus master and the EEPROM read path over the link interface.
// Assumes a byte memory model outside the device and a free running oversampling clock.
`timescale 1ns/1ps

module serial_eeprom_read_path_bench
  import eeprom_pkg::*;
;
  logic ref_clk, ovs_clk, rst, cmd_valid, cmd_ready, rd_valid, done, nack;
  logic low_supply, write_busy, wr_strobe, wr_commit, wr_cancel;
  cmd_op_t cmd_op;
  logic [15:0] cmd_addr, mem_addr, wr_addr;
  logic [7:0] cmd_len, rd_data, mem_rdata, wr_data;
  logic [2:0] cmd_sel, sel_pins;
  int num_errors, compares, cycles, wr_events;
  logic [7:0] rd_q[$];

  eeprom_link_if link();

  // ==========================================================
  // Both ends and the link checker
  eeprom_master i_eeprom_master(.REF_CLK(ref_clk), .RST(rst), .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready),
    .CMD_OP(cmd_op), .CMD_ADDR(cmd_addr), .CMD_LEN(cmd_len), .CMD_SEL(cmd_sel), .RD_VALID(rd_valid),
    .RD_DATA(rd_data), .DONE(done), .NACK(nack), .LINK(link));
  eeprom_device i_eeprom_device(.OVS_CLK(ovs_clk), .RST(rst), .SLAVE_SELECT_BIT0(sel_pins[0]),
    .SLAVE_SELECT_BIT1(sel_pins[1]), .SLAVE_SELECT_BIT2(sel_pins[2]), .LOW_SUPPLY(low_supply),
    .WRITE_BUSY(write_busy), .MEM_RDATA(mem_rdata), .MEM_ADDR(mem_addr), .WR_STROBE(wr_strobe),
    .WR_ADDR(wr_addr), .WR_DATA(wr_data), .WR_COMMIT(wr_commit), .WR_CANCEL(wr_cancel), .LINK(link));
  eeprom_link_chk i_eeprom_link_chk(.ref_clk(ref_clk), .rst(rst), .scl(link.scl), .sda_m_o(link.sda_m_o),
    .sda_m_oe(link.sda_m_oe), .sda_s_o(link.sda_s_o), .sda_s_oe(link.sda_s_oe), .sda(link.sda));

  // Memory contents follow a fixed address pattern
  assign mem_rdata = mem_addr[15:8] ^ mem_addr[7:0] ^ 8'h5A;

  function automatic logic [7:0] exp_byte(input logic [15:0] a);
    return a[15:8] ^ a[7:0] ^ 8'h5A;
  endfunction : exp_byte

  // ==========================================================
  // Clocks, byte capture, write activity, hang guard
  always #50 ref_clk = ~ref_clk;

  initial begin
    ovs_clk = 1'b0;
    #37;
    forever #80 ovs_clk = ~ovs_clk;
  end

  always @(posedge ovs_clk) begin
    if (wr_strobe === 1'b1 || wr_commit === 1'b1 || wr_cancel === 1'b1) wr_events++;
  end

  always @(posedge ref_clk) begin
    cycles++;
    if (rd_valid === 1'b1) rd_q.push_back(rd_data);
    if (cycles == 30000) begin
      num_errors++;
      wrap_up();
    end
  end

  // ==========================================================
  // Tasks
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic do_read(input cmd_op_t op, input logic [15:0] addr, input logic [7:0] len,
                         input logic [2:0] sel, input logic [15:0] first, input int nbytes,
                         input logic exp_nack, input logic [15:0] exp_end);
    int i;
    rd_q.delete();
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_addr <= addr;
    cmd_len <= len;
    cmd_sel <= sel;
    @(posedge ref_clk);
    while (cmd_ready !== 1'b1) @(posedge ref_clk);
    cmd_valid <= 1'b0;
    i = 0;
    do begin
      @(posedge ref_clk);
      #1;
      i++;
    end while (done !== 1'b1 && i < 20000);
    check("done", {15'h0000, done}, 16'h0001);
    check("nack", {15'h0000, nack}, {15'h0000, exp_nack});
    check("byte count", 16'(rd_q.size()), 16'(nbytes));
    for (i = 0; i < rd_q.size(); i++) begin
      check("read byte", {8'h00, rd_q[i]}, {8'h00, exp_byte(first + 16'(i))});
    end
    check("address counter", mem_addr, exp_end);
  endtask : do_read

  task automatic wrap_up();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up

  // ==========================================================
  // Main sequence
  initial begin
    ref_clk = 1'b0;
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = OP_CURRENT;
    cmd_addr = 16'h0000;
    cmd_len = 8'h00;
    cmd_sel = 3'h0;
    sel_pins = 3'h5;
    low_supply = 1'b0;
    write_busy = 1'b0;
    num_errors = 0;
    compares = 0;
    cycles = 0;
    wr_events = 0;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    // Recovery first thing after power-up, counter still at its cleared value
    do_read(OP_RECOVER, 16'h0000, 8'h00, 3'h5, 16'h0000, 0, 1'b0, 16'h0000);
    // Random read across the top of the array
    do_read(OP_RANDOM, 16'hFFFE, 8'h03, 3'h5, 16'hFFFE, 4, 1'b0, 16'h0002);
    // Single byte from the kept counter
    do_read(OP_CURRENT, 16'h0000, 8'h00, 3'h5, 16'h0002, 1, 1'b0, 16'h0003);
    // Each wrong select bit is refused
    for (int k = 0; k < 3; k++) begin
      do_read(OP_CURRENT, 16'h0000, 8'h00, 3'h5 ^ (3'h1 << k), 16'h0000, 0, 1'b1, 16'h0003);
    end
    // Busy internal write blocks the address acknowledge
    @(posedge ref_clk);
    write_busy <= 1'b1;
    do_read(OP_RANDOM, 16'h1234, 8'h00, 3'h5, 16'h0000, 0, 1'b1, 16'h0003);
    @(posedge ref_clk);
    write_busy <= 1'b0;
    low_supply <= 1'b1;
    // Read crosses a page edge with low supply flagged
    do_read(OP_RANDOM, 16'h007F, 8'h01, 3'h5, 16'h007F, 2, 1'b0, 16'h0081);
    @(posedge ref_clk);
    low_supply <= 1'b0;
    // Recovery keeps the counter, then reading resumes
    do_read(OP_RECOVER, 16'h0000, 8'h00, 3'h5, 16'h0000, 0, 1'b0, 16'h0081);
    do_read(OP_CURRENT, 16'h0000, 8'h02, 3'h5, 16'h0081, 3, 1'b0, 16'h0084);
    check("write events", 16'(wr_events), 16'h0000);
    wrap_up();
  end
endmodule : serial_eeprom_read_path_bench
